// ---- i2csf_top.sv ----
// Behaviour
// - stop seen on the bus, from any device, sets the stop flag.
// - writing one to the stop flag bit clears it.
// - tx data copied into the shift register sets tx ready (bit 4).
// - writing tx data, or writing one to bit 4, clears tx ready.
// - tx ready is forced to one while in reset.
// - rx word copied into rx data register sets rx ready (bit 3).
// - rx ready clears on rx data read, write-one, or reset.
// - access-ready flag (bit 2) is driven only as bus master.
// - access-ready clears when programmed contents start being used.
// - access-ready clears on write-one, module reset or chip reset.
// - non-repeat, no stop request: counter at zero sets access-ready.
// - non-repeat with stop request: counter zero makes stop, flag kept.
// - repeat mode: each transmitted word sets access-ready.
// - every flag is pollable and drives its own interrupt request.
// - reading the stop source code clears the stop flag.
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/10ps
`include "i2csf_params.svh"

module i2csf_top (
	// clock, reset, enable
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// engine side
	input wire i2csf_pkg::i2csf_evt_t eng_ev,
	input wire logic [7:0] rx_word,
	output logic [7:0] tx_word,
	output i2csf_pkg::i2csf_mode_t mode,
	output logic gen_stop,
	// interrupts
	output i2csf_pkg::i2csf_flags_t flag_irq,
	output logic irq
);

	// ----------------------------------------
	// functions
	// ----------------------------------------
	function automatic logic i2csf_hit(input logic [7:0] addr, input logic [7:0] ofs);
		i2csf_hit = (addr == ofs);
	endfunction : i2csf_hit

	function automatic logic [2:0] i2csf_code(input i2csf_pkg::i2csf_flags_t pend);
		if (pend[`I2CSF_IDX_REGS_ACCESS_READY_FLAG]) begin
			i2csf_code = `I2CSF_CODE_REGS_ACCESS_READY_FLAG;
		end else if (pend[`I2CSF_IDX_RX]) begin
			i2csf_code = `I2CSF_CODE_RX;
		end else if (pend[`I2CSF_IDX_TX]) begin
			i2csf_code = `I2CSF_CODE_TX;
		end else if (pend[`I2CSF_IDX_STOP]) begin
			i2csf_code = `I2CSF_CODE_STOP;
		end else begin
			i2csf_code = `I2CSF_CODE_NONE;
		end
	endfunction : i2csf_code

	// ----------------------------------------
	// state
	// ----------------------------------------
	i2csf_pkg::i2csf_flags_t flags;
	i2csf_pkg::i2csf_flags_t mask_reg;
	i2csf_pkg::i2csf_mode_t mode_reg;
	logic [7:0] txdata_reg;
	logic [7:0] rxdata_reg;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic [2:0] code_reg;
	logic gen_stop_reg;
	logic lat_reg;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	// read data latched once per transfer, on its first enabled edge
	wire lat_load = ce & psel & ~lat_reg;
	wire access_ph = psel & penable & ce & lat_reg;
	wire hit_status = i2csf_hit(paddr, `I2CSF_OFS_STATUS);
	wire hit_mask = i2csf_hit(paddr, `I2CSF_OFS_MASK);
	wire hit_mode = i2csf_hit(paddr, `I2CSF_OFS_MODE);
	wire hit_tx = i2csf_hit(paddr, `I2CSF_OFS_TXDATA);
	wire hit_rx = i2csf_hit(paddr, `I2CSF_OFS_RXDATA);
	wire hit_isrc = i2csf_hit(paddr, `I2CSF_OFS_INTSRC);
	wire hit_any = hit_status | hit_mask | hit_mode | hit_tx | hit_rx | hit_isrc;
	wire wr_acc = access_ph & pwrite & hit_any;
	wire rd_acc = access_ph & ~pwrite & hit_any;
	wire wr_status = wr_acc & hit_status;
	wire wr_mask = wr_acc & hit_mask;
	wire wr_mode = wr_acc & hit_mode;
	wire wr_tx = wr_acc & hit_tx;
	wire rd_rx = rd_acc & hit_rx;
	wire rd_isrc = rd_acc & hit_isrc;

	assign pready = ce & lat_reg;
	assign pslverr = psel & penable & ~hit_any;

	// ----------------------------------------
	// flag events
	// ----------------------------------------
	i2csf_pkg::i2csf_flags_t pend;
	i2csf_pkg::i2csf_flags_t f_set;
	i2csf_pkg::i2csf_flags_t f_clr;
	i2csf_pkg::i2csf_flags_t f_hold;
	i2csf_pkg::i2csf_flags_t f_hval;
	i2csf_pkg::i2csf_flags_t w1c;
	wire in_reset = ~mode_reg.module_run_bit;
	wire cnt_plain = eng_ev.cnt_zero & ~mode_reg.repeat_select;
	wire code_stop_rd = rd_isrc & (code_reg == `I2CSF_CODE_STOP);

	// write-one clears, zeros ignored
	assign w1c = wr_status ? pwdata[`I2CSF_FLAG_HI:`I2CSF_FLAG_LO] : 4'h0;

	assign f_set[`I2CSF_IDX_STOP] = eng_ev.stop_det;
	assign f_set[`I2CSF_IDX_TX] = eng_ev.tx_copy;
	assign f_set[`I2CSF_IDX_RX] = eng_ev.rx_copy;
	// master only; plain count-to-zero without stop request, or word done in repeat
	assign f_set[`I2CSF_IDX_REGS_ACCESS_READY_FLAG] = mode_reg.master &
		((cnt_plain & ~mode_reg.stop_request_bit) |
		(mode_reg.repeat_select & eng_ev.word_done));

	assign f_clr[`I2CSF_IDX_STOP] = w1c[`I2CSF_IDX_STOP] | code_stop_rd;
	assign f_clr[`I2CSF_IDX_TX] = w1c[`I2CSF_IDX_TX] | wr_tx;
	assign f_clr[`I2CSF_IDX_RX] = w1c[`I2CSF_IDX_RX] | rd_rx;
	assign f_clr[`I2CSF_IDX_REGS_ACCESS_READY_FLAG] = w1c[`I2CSF_IDX_REGS_ACCESS_READY_FLAG] | eng_ev.regs_use;

	// module reset holds tx at one, rx and access-ready at zero
	assign f_hold = {1'b0, in_reset, in_reset, in_reset};
	assign f_hval = `I2CSF_RST_FLAGS;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_flag
			i2csf_flag #(
				.RST_VAL(1'(`I2CSF_RST_FLAGS >> gi))
			) u_flag (
				.sys_clk(sys_clk),
				.rst(rst),
				.ce(ce),
				.hold_en(f_hold[gi]),
				.hold_val(f_hval[gi]),
				.set_ev(f_set[gi]),
				.clr_ev(f_clr[gi]),
				.flag(flags[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	assign pend = flags & mask_reg;
	assign flag_irq = pend;
	assign irq = |pend;

	// ----------------------------------------
	// read data, latched in setup
	// ----------------------------------------
	always_comb begin
		prdata_next = 32'h0000_0000;
		if (hit_status) begin
			prdata_next[`I2CSF_FLAG_HI:`I2CSF_FLAG_LO] = flags;
		end else if (hit_mask) begin
			prdata_next[`I2CSF_FLAG_HI:`I2CSF_FLAG_LO] = mask_reg;
		end else if (hit_mode) begin
			prdata_next[3:0] = mode_reg;
		end else if (hit_tx) begin
			prdata_next[7:0] = txdata_reg;
		end else if (hit_rx) begin
			prdata_next[7:0] = rxdata_reg;
		end else if (hit_isrc) begin
			prdata_next[2:0] = i2csf_code(pend);
		end
	end

	assign prdata = prdata_reg;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			prdata_reg <= 32'h0000_0000;
			code_reg <= `I2CSF_CODE_NONE;
		end else if (lat_load) begin
			prdata_reg <= prdata_next;
			code_reg <= i2csf_code(pend);
		end
	end

	// pready waits for the latch, so a setup frozen by ce still reads fresh data
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lat_reg <= 1'b0;
		end else if (ce) begin
			lat_reg <= psel & ~access_ph;
		end
	end

	// ----------------------------------------
	// software registers
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mask_reg <= `I2CSF_RST_MASK;
			mode_reg <= `I2CSF_RST_MODE;
			txdata_reg <= `I2CSF_RST_TXDATA;
		end else if (ce) begin
			if (wr_mask) begin
				mask_reg <= pwdata[`I2CSF_FLAG_HI:`I2CSF_FLAG_LO];
			end
			if (wr_mode) begin
				mode_reg <= pwdata[3:0];
			end
			if (wr_tx) begin
				txdata_reg <= pwdata[7:0];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rxdata_reg <= `I2CSF_RST_RXDATA;
		end else if (ce && eng_ev.rx_copy) begin
			rxdata_reg <= rx_word;
		end
	end

	// ----------------------------------------
	// stop request at count zero
	// ----------------------------------------
	wire gen_stop_next = mode_reg.master & cnt_plain & mode_reg.stop_request_bit;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			gen_stop_reg <= 1'b0;
		end else if (ce) begin
			gen_stop_reg <= gen_stop_next;
		end
	end

	assign gen_stop = gen_stop_reg;
	assign tx_word = txdata_reg;
	assign mode = mode_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_STOP_SET: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && eng_ev.stop_det) |=> flags[`I2CSF_IDX_STOP])
		else $error("stop flag not set after stop seen");

	AST_STOP_W1C: assert property (@(posedge sys_clk) disable iff (rst)
		(wr_status && pwdata[5] && !eng_ev.stop_det) |=> !flags[`I2CSF_IDX_STOP])
		else $error("stop flag not cleared by write one");

	AST_TX_SET: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && eng_ev.tx_copy) |=> flags[`I2CSF_IDX_TX])
		else $error("tx ready not set after copy");

	AST_TX_WR: assert property (@(posedge sys_clk) disable iff (rst)
		(wr_tx && !eng_ev.tx_copy && mode_reg.module_run_bit) |=> !flags[`I2CSF_IDX_TX])
		else $error("tx ready not cleared by data write");

	AST_TX_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && !mode_reg.module_run_bit) |=> flags[`I2CSF_IDX_TX])
		else $error("tx ready not forced in reset");

	AST_RX_RD: assert property (@(posedge sys_clk) disable iff (rst)
		(rd_rx && !eng_ev.rx_copy) |=> !flags[`I2CSF_IDX_RX])
		else $error("rx ready not cleared by read");

	AST_REGS_ACCESS_READY_FLAG_SLAVE: assert property (@(posedge sys_clk) disable iff (rst)
		(!mode_reg.master && !flags[`I2CSF_IDX_REGS_ACCESS_READY_FLAG]) |=> !flags[`I2CSF_IDX_REGS_ACCESS_READY_FLAG])
		else $error("access ready rose outside master mode");

	AST_REGS_ACCESS_READY_FLAG_STP: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && mode_reg.module_run_bit && mode_reg.master && cnt_plain &&
		mode_reg.stop_request_bit && !eng_ev.regs_use && !w1c[`I2CSF_IDX_REGS_ACCESS_READY_FLAG])
		|=> (gen_stop && $stable(flags[`I2CSF_IDX_REGS_ACCESS_READY_FLAG])))
		else $error("stop request path disturbed access ready");

	AST_REGS_ACCESS_READY_FLAG_RPT: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && mode_reg.module_run_bit && mode_reg.master && mode_reg.repeat_select &&
		eng_ev.word_done) |=> flags[`I2CSF_IDX_REGS_ACCESS_READY_FLAG])
		else $error("access ready not set after repeat word");

	AST_STOP_CODE: assert property (@(posedge sys_clk) disable iff (rst)
		(rd_isrc && code_reg == `I2CSF_CODE_STOP && !eng_ev.stop_det)
		|=> !flags[`I2CSF_IDX_STOP])
		else $error("stop flag kept after stop code read");

	AST_RX_SET: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && eng_ev.rx_copy && mode_reg.module_run_bit) |=> flags[`I2CSF_IDX_RX])
		else $error("rx ready not set after copy");

	AST_REGS_ACCESS_READY_FLAG_PLAIN: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && mode_reg.module_run_bit && mode_reg.master && !mode_reg.repeat_select &&
		!mode_reg.stop_request_bit && eng_ev.cnt_zero) |=> flags[`I2CSF_IDX_REGS_ACCESS_READY_FLAG])
		else $error("access ready not set at count zero");

	AST_REGS_ACCESS_READY_FLAG_USE: assert property (@(posedge sys_clk) disable iff (rst)
		(ce && eng_ev.regs_use && !eng_ev.cnt_zero && !eng_ev.word_done)
		|=> !flags[`I2CSF_IDX_REGS_ACCESS_READY_FLAG])
		else $error("access ready kept after register use");

endmodule : i2csf_top

// ---- i2csf_params.svh ----
`ifndef I2CSF_PARAMS_SVH
`define I2CSF_PARAMS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define I2CSF_OFS_STATUS 8'h00
`define I2CSF_OFS_MASK 8'h04
`define I2CSF_OFS_MODE 8'h08
`define I2CSF_OFS_TXDATA 8'h0C
`define I2CSF_OFS_RXDATA 8'h10
`define I2CSF_OFS_INTSRC 8'h14

// ----------------------------------------
// field positions
// ----------------------------------------
`define I2CSF_FLAG_LO 2
`define I2CSF_FLAG_HI 5
`define I2CSF_IDX_REGS_ACCESS_READY_FLAG 0
`define I2CSF_IDX_RX 1
`define I2CSF_IDX_TX 2
`define I2CSF_IDX_STOP 3
`define I2CSF_MODE_RUN 0
`define I2CSF_MODE_MASTER 1
`define I2CSF_MODE_REPEAT 2
`define I2CSF_MODE_STOPREQ 3

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define I2CSF_RST_FLAGS 4'h4
`define I2CSF_RST_MASK 4'h0
`define I2CSF_RST_MODE 4'h0
`define I2CSF_RST_TXDATA 8'h00
`define I2CSF_RST_RXDATA 8'h00
`define I2CSF_CODE_NONE 3'h0
`define I2CSF_CODE_REGS_ACCESS_READY_FLAG 3'h3
`define I2CSF_CODE_RX 3'h4
`define I2CSF_CODE_TX 3'h5
`define I2CSF_CODE_STOP 3'h6

`endif

// ---- i2csf_pkg.sv ----
package i2csf_pkg;

	// ----------------------------------------
	// engine events, one-cycle pulses
	// ----------------------------------------
	typedef struct packed {
		logic stop_det;
		logic tx_copy;
		logic rx_copy;
		logic regs_use;
		logic cnt_zero;
		logic word_done;
	} i2csf_evt_t;

	// ----------------------------------------
	// mode control bits
	// ----------------------------------------
	typedef struct packed {
		logic stop_request_bit;
		logic repeat_select;
		logic master;
		logic module_run_bit;
	} i2csf_mode_t;

	typedef logic [3:0] i2csf_flags_t;

endpackage : i2csf_pkg

// ---- i2csf_flag.sv ----
`timescale 1ns/10ps

module i2csf_flag #(
	parameter logic RST_VAL = 1'b0
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	// controls
	input wire logic hold_en,
	input wire logic hold_val,
	input wire logic set_ev,
	input wire logic clr_ev,
	// state
	output logic flag
);

	logic flag_next;

	// hold beats set, set beats clear
	assign flag_next = hold_en ? hold_val : (set_ev ? 1'b1 : (clr_ev ? 1'b0 : flag));

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flag <= RST_VAL;
		end else if (ce) begin
			flag <= flag_next;
		end
	end

endmodule : i2csf_flag

// ---- i2csf_eng_model.sv ----
`timescale 1ns/10ps

module i2csf_eng_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// requests from the bench
	input wire logic [5:0] kick,
	// engine events
	output i2csf_pkg::i2csf_evt_t eng_ev,
	output logic [7:0] rx_word
);
	// ----------------------------------------
	// one-cycle event pulses
	// ----------------------------------------
	assign rx_word = 8'h5A;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			eng_ev <= '0;
		end else begin
			eng_ev <= kick;
		end
	end
endmodule : i2csf_eng_model

// ---- tb_top.sv ----
`timescale 1ns/10ps

module tb_top;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [5:0] kick = 6'h00;
	logic [7:0] rx_word;
	logic [7:0] tx_word;
	logic gen_stop;
	logic irq;
	logic slverr;
	logic [31:0] r;
	int miscompares = 0;
	int n_tests = 0;
	int n_stop = 0;
	i2csf_pkg::i2csf_evt_t eng_ev;
	i2csf_pkg::i2csf_mode_t mode;
	i2csf_pkg::i2csf_flags_t flag_irq;

	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (gen_stop === 1'b1) n_stop++;

	i2csf_eng_model u_eng (.sys_clk(sys_clk), .rst(rst), .kick(kick), .eng_ev(eng_ev),
		.rx_word(rx_word));
	i2csf_top u_dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .eng_ev(eng_ev), .rx_word(rx_word), .tx_word(tx_word),
		.mode(mode), .gen_stop(gen_stop), .flag_irq(flag_irq), .irq(irq));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, s, e);
		end
	endtask : chk

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		r = prdata;
		slverr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task ev(input logic [5:0] m);
		@(posedge sys_clk);
		kick <= m;
		@(posedge sys_clk);
		kick <= 6'h00;
		repeat (2) @(posedge sys_clk);
	endtask : ev

	task st(input logic [31:0] e);
		apb(1'b0, 8'h00, 32'h0);
		chk(r, e);
	endtask : st

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_stop;
		ev(6'h20);
		st(32'h30);
		apb(1'b1, 8'h00, 32'h0);
		st(32'h30);
		apb(1'b1, 8'h00, 32'h20);
		st(32'h10);
		apb(1'b1, 8'h04, 32'h20);
		ev(6'h20);
		chk({31'h0, irq}, 32'h1);
		chk({28'h0, flag_irq}, 32'h8);
		apb(1'b0, 8'h14, 32'h0);
		chk(r, 32'h6);
		st(32'h10);
		chk({31'h0, irq}, 32'h0);
		$display("test stop done");
	endtask : t_stop

	task t_data;
		apb(1'b1, 8'h0C, 32'hC3);
		st(32'h00);
		chk({24'h0, tx_word}, 32'hC3);
		ev(6'h10);
		st(32'h10);
		apb(1'b1, 8'h00, 32'h10);
		st(32'h00);
		ev(6'h08);
		st(32'h08);
		apb(1'b0, 8'h10, 32'h0);
		chk(r, 32'h5A);
		st(32'h00);
		ev(6'h08);
		apb(1'b1, 8'h00, 32'h08);
		st(32'h00);
		apb(1'b0, 8'h20, 32'h0);
		chk({31'h0, slverr}, 32'h1);
		chk(r, 32'h0);
		$display("test data done");
	endtask : t_data

	task t_regs_access_ready_flag;
		apb(1'b1, 8'h08, 32'h3);
		ev(6'h02);
		st(32'h04);
		apb(1'b1, 8'h08, 32'hB);
		n_stop = 0;
		ev(6'h02);
		chk({28'h0, mode}, 32'hB);
		st(32'h04);
		ev(6'h04);
		st(32'h00);
		ev(6'h02);
		st(32'h00);
		chk(n_stop, 32'h2);
		apb(1'b1, 8'h08, 32'h7);
		ev(6'h01);
		st(32'h04);
		apb(1'b1, 8'h00, 32'h04);
		st(32'h00);
		apb(1'b1, 8'h08, 32'h1);
		ev(6'h02);
		st(32'h00);
		apb(1'b1, 8'h08, 32'h3);
		ev(6'h0A);
		st(32'h0C);
		apb(1'b1, 8'h08, 32'h0);
		st(32'h10);
		$display("test access ready done");
	endtask : t_regs_access_ready_flag

	task t_ce;
		apb(1'b1, 8'h08, 32'h1);
		@(posedge sys_clk);
		ce <= 1'b0;
		ev(6'h28);
		fork
			apb(1'b0, 8'h00, 32'h0);
			begin
				repeat (4) @(posedge sys_clk);
				ce <= 1'b1;
			end
		join
		chk(r, 32'h10);
		$display("test clock enable done");
	endtask : t_ce

	task t_rst;
		apb(1'b1, 8'h08, 32'h3);
		apb(1'b1, 8'h04, 32'h3C);
		ev(6'h0A);
		st(32'h1C);
		chk({31'h0, irq}, 32'h1);
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		st(32'h10);
		chk({31'h0, irq}, 32'h0);
		chk({28'h0, mode}, 32'h0);
		apb(1'b0, 8'h04, 32'h0);
		chk(r, 32'h0);
		$display("test chip reset done");
	endtask : t_rst

	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		st(32'h10);
		apb(1'b0, 8'h04, 32'h0);
		chk(r, 32'h0);
		apb(1'b1, 8'h08, 32'h1);
		t_stop;
		t_data;
		t_regs_access_ready_flag;
		t_ce;
		t_rst;
		tally_and_finish;
	end

	initial begin
		#250000;
		miscompares++;
		tally_and_finish;
	end
endmodule : tb_top
